// ---- pkg/stack_pop_pkg.sv ----
// Package with types and constants for the memory word stack unit
package stack_pop_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 32;
  // Control word offsets from the stack base word
  localparam logic [ADDR_W-1:0] LAST_LO_OFS = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] LAST_HI_OFS = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] PTR_LO_OFS = 32'h0000_0002;
  localparam logic [ADDR_W-1:0] PTR_HI_OFS = 32'h0000_0003;
  localparam logic [ADDR_W-1:0] DATA_OFS = 32'h0000_0004;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ONE_ADDR = 32'h0000_0001;

  typedef enum logic [1:0] {
    OP_DEFINE,
    OP_PUSH,
    OP_OLDEST_POP,
    OP_NEWEST_POP
  } op_t;

  // Operation request from the sequencer
  typedef struct packed {
    logic cond;
    logic edge_mode;
    op_t op;
    logic [ADDR_W-1:0] base;
    logic [WORD_W-1:0] len;
    logic [WORD_W-1:0] src;
  } op_req_t;

  // Memory request toward the data memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } mem_req_t;
endpackage

// ---- design/memory_word_stack_pop_unit.sv ----
// Stack engine that defines, pushes and pops a word stack in data memory
//
// Overview of operation
// - Oldest pop reads first data word
// - Oldest pop decrements pointer, shifts data down
// - Oldest pop leaves old pointer word intact
// - Pop underflow sets error flag, else clears
// - Newest pop reads pointer word, decrements pointer
// - Newest pop leaves read word unmodified
// - First four base words are control words
// - Data sits from base+4 to last word
// - Run every cycle or on rising edge
// - Push writes pointer word, increments pointer
// - Push beyond last word sets error flag
// - Define zeroes data, pointer to first data
// - Last address and pointer span two words
`timescale 1ns/100ps
module memory_word_stack_pop_unit
(
  input wire logic clk,
  input wire logic rst,
  input stack_pop_pkg::op_req_t req,
  output logic busy,
  output logic done,
  output stack_pop_pkg::mem_req_t mem,
  input wire logic [stack_pop_pkg::WORD_W-1:0] mem_rdata,
  output logic [stack_pop_pkg::WORD_W-1:0] dest_word,
  output logic dest_valid,
  output logic error_flag
);
  import stack_pop_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_RD_LL, S_RD_LH, S_RD_PL, S_RD_PH, S_DECIDE,
    S_ZERO, S_SHIFT_RD, S_SHIFT_WR, S_DATA, S_WR_PL, S_WR_PH, S_WR_LL, S_WR_LH, S_DONE
  } state_t;

  state_t state, next_state;
  op_t op, next_op;
  logic [ADDR_W-1:0] base, next_base;
  logic [ADDR_W-1:0] last, next_last;
  logic [ADDR_W-1:0] ptr, next_ptr;
  logic [ADDR_W-1:0] cur, next_cur;
  logic [WORD_W-1:0] src, next_src;
  logic [WORD_W-1:0] next_dest;
  logic next_dest_valid, next_error;
  logic cond_q, next_cond_q;
  logic start;

  // Word address relative to the stack base
  function automatic logic [ADDR_W-1:0] at(input logic [ADDR_W-1:0] b,
                                            input logic [ADDR_W-1:0] ofs);
    return b + ofs;
  endfunction

  // Level mode triggers every idle cycle, edge mode only on a rise
  assign start = req.cond & (~req.edge_mode | ~cond_q);
  assign busy = (state != S_IDLE);
  assign done = (state == S_DONE);

  // Next state and datapath for the whole sequence
  always_comb begin
    next_state = state;
    next_op = op;
    next_base = base;
    next_last = last;
    next_ptr = ptr;
    next_cur = cur;
    next_src = src;
    next_dest = dest_word;
    next_dest_valid = 1'b0;
    next_error = error_flag;
    next_cond_q = req.cond;
    mem = '0;
    case (state)
      S_IDLE: begin
        // Requests during a sequence are ignored, so each op is atomic
        if (start) begin
          next_op = req.op;
          next_base = req.base;
          next_src = req.src;
          if (req.op == OP_DEFINE) begin
            next_last = at(req.base, {16'h0000, req.len} - ONE_ADDR);
            next_cur = at(req.base, DATA_OFS);
            next_state = S_ZERO;
          end else begin
            next_state = S_RD_LL;
          end
        end
      end
      S_RD_LL: begin
        mem.rd = 1'b1;
        mem.addr = at(base, LAST_LO_OFS);
        next_state = S_RD_LH;
      end
      S_RD_LH: begin
        next_last[WORD_W-1:0] = mem_rdata;
        mem.rd = 1'b1;
        mem.addr = at(base, LAST_HI_OFS);
        next_state = S_RD_PL;
      end
      S_RD_PL: begin
        next_last[ADDR_W-1:WORD_W] = mem_rdata;
        mem.rd = 1'b1;
        mem.addr = at(base, PTR_LO_OFS);
        next_state = S_RD_PH;
      end
      S_RD_PH: begin
        next_ptr[WORD_W-1:0] = mem_rdata;
        mem.rd = 1'b1;
        mem.addr = at(base, PTR_HI_OFS);
        next_state = S_DECIDE;
      end
      S_DECIDE: begin
        next_ptr[ADDR_W-1:WORD_W] = mem_rdata;
        if (op == OP_PUSH) begin
          // Pointer past the last data word means no room left
          next_error = ({mem_rdata, ptr[WORD_W-1:0]} > last);
        end else begin
          // Empty stack: pointer not above the first data word
          next_error = ({mem_rdata, ptr[WORD_W-1:0]} <= at(base, DATA_OFS));
        end
        // A failed check moves no data and leaves the stored pointer alone
        next_state = next_error ? S_DONE : S_DATA;
      end
      S_DATA: begin
        if (op == OP_PUSH) begin
          mem.wr = 1'b1;
          mem.addr = ptr;
          mem.wdata = src;
          next_ptr = ptr + ONE_ADDR;
          next_state = S_WR_PL;
        end else if (op == OP_NEWEST_POP) begin
          // Read only; the word stays in memory
          mem.rd = 1'b1;
          mem.addr = ptr;
          next_ptr = ptr - ONE_ADDR;
          next_cur = ZERO_ADDR;
          next_state = S_SHIFT_RD;
        end else begin
          mem.rd = 1'b1;
          mem.addr = at(base, DATA_OFS);
          next_cur = at(base, DATA_OFS) + ONE_ADDR;
          next_ptr = ptr - ONE_ADDR;
          next_state = S_SHIFT_RD;
        end
      end
      S_SHIFT_RD: begin
        // First cycle here captures the popped word
        if (cur == ZERO_ADDR || cur == at(base, DATA_OFS) + ONE_ADDR) begin
          next_dest = mem_rdata;
        end
        if (op == OP_NEWEST_POP) begin
          next_state = S_WR_PL;
        end else if (cur >= ptr + ONE_ADDR) begin
          // Word at the old pointer is never written by the shift
          next_state = S_WR_PL;
        end else begin
          mem.rd = 1'b1;
          mem.addr = cur;
          next_state = S_SHIFT_WR;
        end
      end
      S_SHIFT_WR: begin
        // Move each remaining word one place toward the base
        mem.wr = 1'b1;
        mem.addr = cur - ONE_ADDR;
        mem.wdata = mem_rdata;
        next_cur = cur + ONE_ADDR;
        next_state = S_SHIFT_RD;
      end
      S_ZERO: begin
        if (cur > last) begin
          next_ptr = at(base, DATA_OFS);
          next_error = 1'b0;
          next_state = S_WR_PL;
        end else begin
          mem.wr = 1'b1;
          mem.addr = cur;
          mem.wdata = ZERO_WORD;
          next_cur = cur + ONE_ADDR;
        end
      end
      S_WR_PL: begin
        mem.wr = 1'b1;
        mem.addr = at(base, PTR_LO_OFS);
        mem.wdata = ptr[WORD_W-1:0];
        next_state = S_WR_PH;
      end
      S_WR_PH: begin
        mem.wr = 1'b1;
        mem.addr = at(base, PTR_HI_OFS);
        mem.wdata = ptr[ADDR_W-1:WORD_W];
        // Only define records the last word address; push and pop just read it
        next_state = (op == OP_DEFINE) ? S_WR_LL : S_DONE;
      end
      S_WR_LL: begin
        mem.wr = 1'b1;
        mem.addr = at(base, LAST_LO_OFS);
        mem.wdata = last[WORD_W-1:0];
        next_state = S_WR_LH;
      end
      S_WR_LH: begin
        mem.wr = 1'b1;
        mem.addr = at(base, LAST_HI_OFS);
        mem.wdata = last[ADDR_W-1:WORD_W];
        next_state = S_DONE;
      end
      S_DONE: begin
        next_dest_valid = ~error_flag &
                          ((op == OP_OLDEST_POP) | (op == OP_NEWEST_POP));
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      op <= OP_DEFINE;
      base <= ZERO_ADDR;
      last <= ZERO_ADDR;
      ptr <= ZERO_ADDR;
      cur <= ZERO_ADDR;
      src <= ZERO_WORD;
      dest_word <= ZERO_WORD;
      dest_valid <= 1'b0;
      error_flag <= 1'b0;
      cond_q <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      base <= next_base;
      last <= next_last;
      ptr <= next_ptr;
      cur <= next_cur;
      src <= next_src;
      dest_word <= next_dest;
      dest_valid <= next_dest_valid;
      error_flag <= next_error;
      cond_q <= next_cond_q;
    end
  end

  // Oldest pop reads the first data word right after the checks pass
  a_oldest_read_addr: assert property (@(posedge clk) disable iff (rst)
    (state == S_DATA && op == OP_OLDEST_POP) |-> (mem.rd && mem.addr == base + DATA_OFS))
    else $error("oldest pop read wrong address");

  // Pop never writes the word at its original pointer
  a_old_ptr_kept: assert property (@(posedge clk) disable iff (rst)
    (mem.wr && (op == OP_OLDEST_POP) && state == S_SHIFT_WR) |-> (mem.addr < ptr + ONE_ADDR))
    else $error("shift overwrote old pointer word");

  // Underflow result, worked from the full pointer just read back
  a_pop_underflow: assert property (@(posedge clk) disable iff (rst)
    (state == S_DECIDE && op != OP_PUSH && op != OP_DEFINE) |=>
      (error_flag == ({$past(mem_rdata), $past(ptr[WORD_W-1:0])} <= $past(base) + DATA_OFS)))
    else $error("underflow flag wrong");

  // Newest pop never writes to data memory except pointer words
  a_newest_no_write: assert property (@(posedge clk) disable iff (rst)
    (op == OP_NEWEST_POP && mem.wr) |-> (state == S_WR_PL || state == S_WR_PH))
    else $error("newest pop wrote data");

  // Newest pop decrements the pointer by exactly one
  a_newest_dec: assert property (@(posedge clk) disable iff (rst)
    (state == S_DATA && op == OP_NEWEST_POP) |=> (ptr == $past(ptr) - ONE_ADDR))
    else $error("newest pop pointer not decremented");

  // Push increments and writes the source at the pointer
  a_push_write: assert property (@(posedge clk) disable iff (rst)
    (state == S_DATA && op == OP_PUSH) |-> (mem.wr && mem.addr == ptr && mem.wdata == src)
      ##1 (ptr == $past(ptr) + ONE_ADDR))
    else $error("push write or increment wrong");

  // Edge mode does not retrigger while condition stays high
  a_edge_once: assert property (@(posedge clk) disable iff (rst)
    (state == S_IDLE && req.cond && req.edge_mode && cond_q) |=> (state == S_IDLE))
    else $error("edge mode retriggered");

  // Requests arriving during a sequence leave the taken operation alone
  a_atomic_op: assert property (@(posedge clk) disable iff (rst)
    busy |=> (op == $past(op) && base == $past(base) && src == $past(src)))
    else $error("request taken while busy");

  // Define clears the error flag and sets pointer to first data word
  a_define_ptr: assert property (@(posedge clk) disable iff (rst)
    (state == S_ZERO && cur > last) |=> (ptr == base + DATA_OFS && !error_flag))
    else $error("define pointer wrong");
endmodule

// ---- dv/data_memory_model.sv ----
// Behavioural word-addressed data memory that holds the stack
`timescale 1ns/100ps
module data_memory_model
  import stack_pop_pkg::*;
(
  input wire logic clk,
  input stack_pop_pkg::mem_req_t mem,
  output logic [stack_pop_pkg::WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] words [0:255];
  // Preload a pattern so a missed clear or shift shows up
  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 256; i++) words[i] = 16'hC3A5 ^ 16'(i);
  end
  // One-cycle read; outside a read the lines toggle, so stale data never passes
  always @(posedge clk) begin
    if (mem.rd) mem_rdata <= words[mem.addr[7:0]];
    else mem_rdata <= ~mem_rdata;
    if (mem.wr) words[mem.addr[7:0]] <= mem.wdata;
  end
endmodule

// ---- dv/tb_memory_word_stack_pop_unit.sv ----
// Self-checking bench for the word stack unit against a memory model
`timescale 1ns/100ps
module tb_memory_word_stack_pop_unit;
  import stack_pop_pkg::*;
  localparam logic [31:0] STK_BASE = 32'h0000_0020;
  localparam logic [15:0] STK_LEN = 16'h000A;
  localparam logic [31:0] STK_LAST = STK_BASE + {16'h0000, STK_LEN} - ONE_ADDR;
  logic clk = 1'b0;
  logic rst = 1'b1;
  op_req_t req;
  mem_req_t mem;
  logic busy, done, dest_valid, error_flag, exp_err, exp_dv, dv;
  logic [15:0] mem_rdata, dest_word, exp_dest;
  logic [15:0] exp_mem [0:255];
  logic [31:0] rp;
  logic [31:0] seed = 32'h4258;
  int cnt;
  int n_mismatch = 0;
  int comparisons = 0;
  always #4 clk = ~clk;
  memory_word_stack_pop_unit DUT (.clk(clk), .rst(rst), .req(req), .busy(busy), .done(done),
    .mem(mem), .mem_rdata(mem_rdata), .dest_word(dest_word), .dest_valid(dest_valid),
    .error_flag(error_flag));
  data_memory_model mem_model (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference stack: control words, data region and expected outputs
  function automatic void ref_op(input op_t op, input logic [15:0] src);
    int b;
    b = int'(STK_BASE);
    exp_err = 1'b0;
    exp_dv = 1'b0;
    case (op)
      OP_DEFINE: begin
        rp = STK_BASE + DATA_OFS;
        for (int a = 4; a < int'(STK_LEN); a++) exp_mem[b + a] = ZERO_WORD;
        exp_mem[b] = STK_LAST[15:0];
        exp_mem[b + 1] = STK_LAST[31:16];
      end
      OP_PUSH: begin
        if (rp > STK_LAST) exp_err = 1'b1;
        else begin
          exp_mem[rp[7:0]] = src;
          rp = rp + ONE_ADDR;
        end
      end
      OP_OLDEST_POP: begin
        if (rp <= STK_BASE + DATA_OFS) exp_err = 1'b1;
        else begin
          exp_dest = exp_mem[b + 4];
          exp_dv = 1'b1;
          for (int a = b + 4; a < int'(rp) - 1; a++) exp_mem[a] = exp_mem[a + 1];
          rp = rp - ONE_ADDR;
        end
      end
      default: begin
        if (rp <= STK_BASE + DATA_OFS) exp_err = 1'b1;
        else begin
          exp_dest = exp_mem[rp[7:0]];
          rp = rp - ONE_ADDR;
          exp_dv = 1'b1;
        end
      end
    endcase
    exp_mem[b + 2] = rp[15:0];
    exp_mem[b + 3] = rp[31:16];
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_region();
    for (int a = 0; a < int'(STK_LEN); a++) begin
      chk("stack word", exp_mem[int'(STK_BASE) + a], mem_model.words[int'(STK_BASE) + a]);
    end
  endtask
  // One edge-mode operation; cond is held on to prove it runs only once
  task automatic run(input op_t op, input logic [15:0] src);
    int n;
    @(posedge clk);
    #1 req.op = op;
    req.src = src;
    req.cond = 1'b1;
    n = 0;
    dv = 1'b0;
    // Two falling edges in, the start edge has passed and the unit is working
    repeat (2) @(negedge clk);
    chk("busy", 1, busy);
    repeat (58) begin
      @(negedge clk);
      if (done === 1'b1) n++;
      if (dest_valid === 1'b1) dv = 1'b1;
    end
    @(posedge clk);
    #1 req.cond = 1'b0;
    ref_op(op, src);
    chk("done count", 1, n);
    chk("dest valid", exp_dv, dv);
    if (exp_dv) chk("dest word", exp_dest, dest_word);
    if (op != OP_DEFINE) chk("error flag", exp_err, error_flag);
    chk("busy", 0, busy);
    chk_region();
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well above the expected run of about 3400 cycles
  initial begin
    #160000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    req = '{cond: 1'b0, edge_mode: 1'b1, op: OP_DEFINE, base: STK_BASE, len: STK_LEN,
      src: 16'h0000};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    // Expected memory starts from the model's preload, so reads past the data show up
    foreach (exp_mem[i]) exp_mem[i] = mem_model.words[i];
    run(OP_DEFINE, 16'h0000);
    run(OP_NEWEST_POP, 16'h0000);
    run(OP_OLDEST_POP, 16'h0000);
    for (int i = 0; i < 7; i++) run(OP_PUSH, 16'h1000 + 16'(i));
    run(OP_OLDEST_POP, 16'h0000);
    run(OP_OLDEST_POP, 16'h0000);
    run(OP_NEWEST_POP, 16'h0000);
    // Level mode: repeats while cond is on, stopped after the second pass
    @(posedge clk);
    #1 req.edge_mode = 1'b0;
    req.op = OP_PUSH;
    req.src = 16'h5A5A;
    req.cond = 1'b1;
    cnt = 0;
    repeat (80) begin
      @(negedge clk);
      if (done === 1'b1) cnt++;
      if (cnt == 2) break;
    end
    @(posedge clk);
    #1 req.cond = 1'b0;
    req.edge_mode = 1'b1;
    ref_op(OP_PUSH, 16'h5A5A);
    ref_op(OP_PUSH, 16'h5A5A);
    repeat (30) @(posedge clk);
    chk("level count", 2, cnt);
    chk_region();
    // Random mix biased toward pushes
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      run(op_t'(seed[1] ? seed[1:0] : 2'b01), seed[23:8]);
    end
    run(OP_DEFINE, 16'h0000);
    tally_and_finish();
  end
endmodule
